// >>> logic/level_sync.sv
// two-stage synchroniser for the remote on/off pin
`timescale 1ns/1ps
module level_sync
	import output_enable_pkg::*;
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic async_in,
	output logic      sync_out
);
	typedef struct packed {
		logic first;
		logic second;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	// first stage feeds only the second; open pin idles high
	always_comb begin
		next_state.first = async_in;
		next_state.second = state.first;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= '{first: 1'b1, second: 1'b1};
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.second;
endmodule

// >>> logic/low_pulse_detect.sv
// fires once when the input has been low for the minimum width
`timescale 1ns/1ps
module low_pulse_detect
	import output_enable_pkg::*;
#(
	parameter int CYCLES = LATCH_OFF_CYCLES
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic level,
	output logic      fire
);
	localparam int W = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [W-1:0] count;
		logic         fire;
	} detect_state_type;

	detect_state_type state;
	detect_state_type next_state;

	// count low cycles, saturate, pulse once at the threshold
	always_comb begin
		next_state = state;
		next_state.fire = 1'b0;
		if (level) begin
			next_state.count = '0;
		end else if (state.count != W'(CYCLES)) begin
			next_state.count = state.count + 1'b1;
			next_state.fire = (state.count == W'(CYCLES - 1));
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign fire = state.fire;
endmodule

// >>> logic/output_enable_control.sv
// output-enable control with remote pin policy, apb registers and persistence strobes
//
// Overview of operation
// - high_enables: output on while pin is 1 or open, off while 0
// - low_enables: output on while pin is 0 or shorted, off while 1
// - high_inhibits: pin 1 forces off; pin 0 lets requests decide
// - low_inhibits: pin 0 forces off; pin 1 lets requests decide
// - low_pulse_latch_off: 100 us low turns off; on-command or standby key re-enables
// - disabled policy ignores every pin level
// - enables policies ignore standby key and output on/off commands
// - policy resets to high_inhibits
// - state command rejected with -221 on pin control, inhibit or running list
// - accepted state command 0 turns output off, 1 turns it on
// - state query reads 0 when disabled, 1 when enabled
// - entering remote mode leaves output state unchanged
// - powers up local with output request on; power-up bit is stored and read back but reset always loads OUT_ON_RESET
// - policy query returns the configured policy of six
// - load type selects energetic, passive or cell turn-off behaviour
// - comm group save stores address, language, setup and pin policy
// - uart group save stores port state, baud, pacing and echo
// - bounds group save stores limits and maximum protection values
// - display group save stores contrast and background
// - load group save stores selected load type
// - list with sample needs loop count 1, else error -100
// - load type query returns energetic, passive or cell
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module output_enable_control
	import output_enable_pkg::*;
#(
	parameter int LATCH_CYCLES = LATCH_OFF_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        remote_pin,
	input  wire logic        standby_key,
	input  wire logic        list_done,
	output logic             output_enable,
	output logic             inhibit_active,
	output logic [1:0]       load_select,
	output logic [4:0]       nv_save,
	output logic [2:0]       nv_policy,
	output logic [1:0]       nv_load
);
	typedef struct packed {
		policy_type    policy;
		load_type_type load;
		logic          out_on;
		logic          enable;
		logic          inhibit;
		logic          remote;
		logic          pwrup_on;
		logic          list_run;
		logic          list_sample;
		logic [7:0]    list_count;
		logic [15:0]   err;
		logic [4:0]    save;
		policy_type    saved_policy;
		load_type_type saved_load;
		logic [31:0]   rdata;
	} ctrl_state_type;

	ctrl_state_type state;
	ctrl_state_type next_state;

	logic pin;
	logic latch_fire;
	logic setup;
	logic access_wr;
	logic mapped;
	logic pin_ctrl;
	logic inhibit_now;
	logic blocked;
	logic start_list;

	// pin into clock domain and low-width
	level_sync u_sync (
		.clock    (clock),
		.resetn   (resetn),
		.async_in (remote_pin),
		.sync_out (pin)
	);

	low_pulse_detect #(
		.CYCLES (LATCH_CYCLES)
	) u_detect (
		.clock  (clock),
		.resetn (resetn),
		.level  (pin),
		.fire   (latch_fire)
	);

	// bus decode; no wait states
	assign setup = psel && !penable;
	assign access_wr = psel && penable && pwrite && mapped;
	assign mapped = (paddr == CONFIG_OFFSET) || (paddr == OUTPUT_OFFSET) ||
		(paddr == LIST_OFFSET) || (paddr == ERROR_OFFSET) || (paddr == PERSIST_OFFSET);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// policy classification
	assign pin_ctrl = (state.policy == POL_HIGH_ENABLES) ||
		(state.policy == POL_LOW_ENABLES);
	assign inhibit_now = ((state.policy == POL_HIGH_INHIBITS) && pin) ||
		((state.policy == POL_LOW_INHIBITS) && !pin);
	assign blocked = pin_ctrl || inhibit_now || state.list_run;
	assign start_list = access_wr && (paddr == LIST_OFFSET) && pwdata[RUN_BIT];

	// next-state logic
	always_comb begin
		next_state = state;
		next_state.save = '0;

		// software register writes
		if (access_wr) begin
			case (paddr)
				CONFIG_OFFSET: begin
					if (pwdata[POLICY_LSB +: 3] <= 3'(POL_LOW_PULSE_LATCH_OFF)) begin
						next_state.policy = policy_type'(pwdata[POLICY_LSB +: 3]);
					end
					if (pwdata[LOAD_LSB +: 2] <= 2'(LOAD_CELL)) begin
						next_state.load = load_type_type'(pwdata[LOAD_LSB +: 2]);
					end
					next_state.remote = pwdata[REMOTE_BIT]; // out_on untouched
					next_state.pwrup_on = pwdata[PWRUP_BIT];
				end
				OUTPUT_OFFSET: begin
					if (!blocked) begin
						next_state.out_on = pwdata[STATE_BIT];
					end
				end
				LIST_OFFSET: begin
					next_state.list_sample = pwdata[SAMPLE_BIT];
					next_state.list_count = pwdata[COUNT_LSB +: 8];
					next_state.list_run = pwdata[RUN_BIT];
					if (pwdata[RUN_BIT] && pwdata[SAMPLE_BIT] &&
						pwdata[COUNT_LSB +: 8] != SAMPLE_LOOPS) begin
						next_state.list_run = 1'b0;
					end
				end
				ERROR_OFFSET: begin
					next_state.err = ERR_NONE;
				end
				PERSIST_OFFSET: begin
					next_state.save = pwdata[GROUP_COUNT-1:0];
					if (pwdata[GROUP_COMM]) begin
						next_state.saved_policy = state.policy;
					end
					if (pwdata[GROUP_LOAD]) begin
						next_state.saved_load = state.load;
					end
				end
				default: begin
					next_state.save = '0;
				end
			endcase
		end

		// list ends from the waveform engine; a new start wins
		if (list_done && !start_list) begin
			next_state.list_run = 1'b0;
		end

		// errors are set after any clear so a same-cycle event survives
		if (access_wr && paddr == OUTPUT_OFFSET && blocked) begin
			next_state.err = ERR_CONFLICT;
		end
		if (start_list && pwdata[SAMPLE_BIT] && pwdata[COUNT_LSB +: 8] != SAMPLE_LOOPS) begin
			next_state.err = ERR_COMMAND;
		end

		// front-panel standby key toggles the request unless blocked
		if (standby_key && !blocked) begin
			next_state.out_on = !state.out_on;
		end

		// latch-off policy: pin level high never re-enables
		if (state.policy == POL_LOW_PULSE_LATCH_OFF && latch_fire) begin
			next_state.out_on = 1'b0;
		end

		// resolve the output from policy and pin
		next_state.inhibit = inhibit_now;
		case (state.policy)
			POL_HIGH_ENABLES:  next_state.enable = pin;
			POL_LOW_ENABLES:   next_state.enable = !pin;
			POL_HIGH_INHIBITS: next_state.enable = state.out_on && !pin;
			POL_LOW_INHIBITS:  next_state.enable = state.out_on && pin;
			default:           next_state.enable = state.out_on;
		endcase

		// read data captured in the setup cycle
		if (setup) begin
			next_state.rdata = '0;
			case (paddr)
				CONFIG_OFFSET: begin
					next_state.rdata[POLICY_LSB +: 3] = state.policy;
					next_state.rdata[LOAD_LSB +: 2] = state.load;
					next_state.rdata[REMOTE_BIT] = state.remote;
					next_state.rdata[PWRUP_BIT] = state.pwrup_on;
				end
				OUTPUT_OFFSET: begin
					next_state.rdata[STATE_BIT] = state.enable;
					next_state.rdata[INHIBIT_BIT] = state.inhibit;
					next_state.rdata[REQUEST_BIT] = state.out_on;
				end
				LIST_OFFSET: begin
					next_state.rdata[RUN_BIT] = state.list_run;
					next_state.rdata[SAMPLE_BIT] = state.list_sample;
					next_state.rdata[COUNT_LSB +: 8] = state.list_count;
				end
				ERROR_OFFSET: begin
					next_state.rdata[15:0] = state.err;
				end
				PERSIST_OFFSET: begin
					next_state.rdata[POLICY_LSB +: 3] = state.saved_policy;
					next_state.rdata[LOAD_LSB +: 2] = state.saved_load;
				end
				default: begin
					next_state.rdata = '0;
				end
			endcase
		end
	end

	// state register; power-up local with output request on
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= '{
				policy: POLICY_RESET, load: LOAD_RESET, out_on: OUT_ON_RESET,
				enable: 1'b0, inhibit: 1'b0, remote: 1'b0, pwrup_on: OUT_ON_RESET,
				list_run: 1'b0, list_sample: 1'b0, list_count: SAMPLE_LOOPS,
				err: ERR_NONE, save: '0, saved_policy: POLICY_RESET,
				saved_load: LOAD_RESET, rdata: '0
			};
		end else begin
			state <= next_state;
		end
	end

	// outputs
	assign prdata = state.rdata;
	assign output_enable = state.enable;
	assign inhibit_active = state.inhibit;
	assign load_select = state.load;
	assign nv_save = state.save;
	assign nv_policy = state.saved_policy;
	assign nv_load = state.saved_load;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	property p_high_enables;
		(state.policy == POL_HIGH_ENABLES) |=> (output_enable == $past(pin));
	endproperty
	a_high_enables: assert property (p_high_enables) else $error("high_enables wrong");

	property p_low_enables;
		(state.policy == POL_LOW_ENABLES) |=> (output_enable == !$past(pin));
	endproperty
	a_low_enables: assert property (p_low_enables) else $error("low_enables wrong");

	property p_high_inhibits;
		(state.policy == POL_HIGH_INHIBITS && pin) |=> !output_enable && inhibit_active;
	endproperty
	a_high_inhibits: assert property (p_high_inhibits) else $error("not inhibited");

	property p_low_inhibits;
		(state.policy == POL_LOW_INHIBITS && !pin) |=> !output_enable && inhibit_active;
	endproperty
	a_low_inhibits: assert property (p_low_inhibits) else $error("not inhibited");

	property p_latch_off;
		(state.policy == POL_LOW_PULSE_LATCH_OFF && latch_fire) |=> !state.out_on;
	endproperty
	a_latch_off: assert property (p_latch_off) else $error("latch-off missed");

	property p_disabled;
		(state.policy == POL_DISABLED) |=> (output_enable == $past(state.out_on));
	endproperty
	a_disabled: assert property (p_disabled) else $error("pin not ignored");

	property p_key_blocked;
		(standby_key && pin_ctrl && !access_wr) |=> $stable(state.out_on);
	endproperty
	a_key_blocked: assert property (p_key_blocked) else $error("key acted");

	property p_conflict;
		(access_wr && paddr == OUTPUT_OFFSET && blocked && !latch_fire) |=>
			(state.err == ERR_CONFLICT) && $stable(state.out_on);
	endproperty
	a_conflict: assert property (p_conflict) else $error("conflict not posted");

	property p_accept;
		(access_wr && paddr == OUTPUT_OFFSET && !blocked && !standby_key && !latch_fire)
			|=> (state.out_on == $past(pwdata[STATE_BIT])) ##1 (output_enable || blocked
			|| state.out_on == 1'b0);
	endproperty
	a_accept: assert property (p_accept) else $error("state command lost");

	property p_sample_count;
		(start_list && pwdata[SAMPLE_BIT] && pwdata[COUNT_LSB +: 8] != SAMPLE_LOOPS)
			|=> (state.err == ERR_COMMAND) && !state.list_run;
	endproperty
	a_sample_count: assert property (p_sample_count) else $error("loop count ok");

	// a free standby key must toggle the request
	property p_key_toggle;
		(standby_key && !blocked && !access_wr && !latch_fire) |=>
			(state.out_on != $past(state.out_on));
	endproperty
	a_key_toggle: assert property (p_key_toggle) else $error("key ignored");

	// state query reports the enable seen in the setup cycle
	property p_state_query;
		(setup && paddr == OUTPUT_OFFSET) |=> (prdata[STATE_BIT] == $past(output_enable));
	endproperty
	a_state_query: assert property (p_state_query) else $error("state query wrong");

	// config query reports policy and load type
	property p_policy_query;
		(setup && paddr == CONFIG_OFFSET) |=>
			(prdata[POLICY_LSB +: 3] == $past(state.policy)) &&
			(prdata[LOAD_LSB +: 2] == $past(state.load));
	endproperty
	a_policy_query: assert property (p_policy_query) else $error("config query wrong");

	// a config write, remote mode included, never moves the request
	property p_remote_keeps;
		(access_wr && paddr == CONFIG_OFFSET && !standby_key && !latch_fire) |=>
			$stable(state.out_on);
	endproperty
	a_remote_keeps: assert property (p_remote_keeps) else $error("output moved");

	// persist write pulses exactly the requested group strobes
	property p_persist;
		(access_wr && paddr == PERSIST_OFFSET) |=>
			(nv_save == $past(pwdata[GROUP_COUNT-1:0]));
	endproperty
	a_persist: assert property (p_persist) else $error("save strobe wrong");

	cover property (state.policy == POL_LOW_PULSE_LATCH_OFF && latch_fire);
	cover property (access_wr && paddr == OUTPUT_OFFSET && blocked);
	cover property (state.policy == POL_HIGH_INHIBITS && $fell(output_enable));
	cover property (access_wr && paddr == PERSIST_OFFSET);
	cover property (standby_key && !blocked);
endmodule

// >>> logic/output_enable_pkg.sv
// shared constants and types of the output-enable control block
package output_enable_pkg;

	// apb register byte offsets
	localparam logic [7:0] CONFIG_OFFSET  = 8'h00;
	localparam logic [7:0] OUTPUT_OFFSET  = 8'h04;
	localparam logic [7:0] LIST_OFFSET    = 8'h08;
	localparam logic [7:0] ERROR_OFFSET   = 8'h0C;
	localparam logic [7:0] PERSIST_OFFSET = 8'h10;

	// config register fields
	localparam int POLICY_LSB  = 0;
	localparam int LOAD_LSB    = 4;
	localparam int REMOTE_BIT  = 8;
	localparam int PWRUP_BIT   = 9;
	// output register fields
	localparam int STATE_BIT   = 0;
	localparam int INHIBIT_BIT = 1;
	localparam int REQUEST_BIT = 2;
	// list register fields
	localparam int RUN_BIT     = 0;
	localparam int SAMPLE_BIT  = 1;
	localparam int COUNT_LSB   = 8;
	// persist register: one bit per group
	localparam int GROUP_COMM    = 0;
	localparam int GROUP_UART    = 1;
	localparam int GROUP_BOUNDS  = 2;
	localparam int GROUP_DISPLAY = 3;
	localparam int GROUP_LOAD    = 4;
	localparam int GROUP_COUNT   = 5;

	// error codes, two's complement of -221 and -100
	localparam logic [15:0] ERR_NONE     = 16'h0000;
	localparam logic [15:0] ERR_CONFLICT = 16'hFF23;
	localparam logic [15:0] ERR_COMMAND  = 16'hFF9C;
	localparam logic [7:0]  SAMPLE_LOOPS = 8'h01;

	// remote on/off pin policies and load types
	typedef enum logic [2:0] {
		POL_DISABLED, POL_HIGH_ENABLES, POL_LOW_ENABLES,
		POL_HIGH_INHIBITS, POL_LOW_INHIBITS, POL_LOW_PULSE_LATCH_OFF
	} policy_type;
	typedef enum logic [1:0] {LOAD_ENERGETIC, LOAD_PASSIVE, LOAD_CELL} load_type_type;

	// reset values
	localparam policy_type    POLICY_RESET = POL_HIGH_INHIBITS;
	localparam load_type_type LOAD_RESET   = LOAD_ENERGETIC;
	localparam logic          OUT_ON_RESET = 1'b1;

	// latch-off pulse width
	localparam int CLOCK_MHZ        = 50;
	localparam int LATCH_OFF_MIN_US = 100;
	localparam int LATCH_OFF_CYCLES = LATCH_OFF_MIN_US * CLOCK_MHZ;

endpackage

// >>> test/remote_switch.sv
// host-side model of the wiring on the remote on/off pin
`timescale 1ns/1ps
module remote_switch (
	input  wire logic drive_en,
	input  wire logic level,
	output wire logic pin
);
	// a released pin is pulled up, so open reads as logic 1
	assign pin = drive_en ? level : 1'b1;
endmodule

// >>> test/tb_output_enable_control.sv
// self-checking testbench of the output-enable control block
`timescale 1ns/1ps
module tb_output_enable_control;
	import output_enable_pkg::*;
	logic        clock = 0;
	logic        resetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic        standby_key = 0;
	logic        list_done = 0;
	logic        pin_en = 1;
	logic        pin_level = 0;
	wire         remote_pin;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        output_enable;
	logic        inhibit_active;
	logic [1:0]  load_select;
	logic [4:0]  nv_save;
	logic [2:0]  nv_policy;
	logic [1:0]  nv_load;
	logic [31:0] rd;
	logic        err;
	int          bad_count = 0;
	int          samples_checked = 0;

	// 50 MHz system clock
	always #10 clock = ~clock;

	remote_switch far (.drive_en(pin_en), .level(pin_level), .pin(remote_pin));

	output_enable_control #(.LATCH_CYCLES(8)) dut (
		.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .remote_pin(remote_pin),
		.standby_key(standby_key), .list_done(list_done),
		.output_enable(output_enable), .inhibit_active(inhibit_active),
		.load_select(load_select), .nv_save(nv_save), .nv_policy(nv_policy),
		.nv_load(nv_load)
	);

	// compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// counts and verdict, then stop
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one apb transfer; data and error taken at the edge with pready high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			bad_count++;
			print_verdict();
		end
		psel <= 0;
		penable <= 0;
	endtask

	// pin level 1 is an open pin, 0 a short to ground
	task set_pin(input logic lvl, input int cycles);
		@(posedge clock);
		pin_en <= !lvl;
		repeat (cycles) @(posedge clock);
		#1;
	endtask

	// let a register update reach the outputs
	task settle;
		repeat (2) @(posedge clock);
		#1;
	endtask

	// one-cycle press of the standby key
	task key;
		@(posedge clock);
		standby_key <= 1;
		@(posedge clock);
		standby_key <= 0;
		settle();
	endtask

	task cfg(input logic [2:0] pol, input logic [1:0] ld);
		apb(1, CONFIG_OFFSET, {26'h0, ld, 1'b0, pol});
	endtask

	// read the error code, then clear it
	task err_is(input logic [15:0] e);
		apb(0, ERROR_OFFSET, 0);
		check(rd, {16'h0, e});
		apb(1, ERROR_OFFSET, 0);
	endtask

	task t_reset;
		#1;
		check(output_enable, 0);
		set_pin(0, 4);
		check(output_enable, 1);
		apb(0, CONFIG_OFFSET, 0);
		check(rd & 32'h337, 32'h203);
		apb(0, LIST_OFFSET, 0);
		check(rd, 32'h100);
		err_is(ERR_NONE);
		check(nv_policy, 3);
		apb(0, 8'h14, 0);
		check(rd, 32'h0);
		check(err, 1'b1);
		$display("reset test done");
	endtask

	task t_inhibit;
		logic inh;
		for (int p = 3; p <= 4; p++) begin
			inh = (p == 3);
			cfg(p, 0);
			set_pin(inh, 4);
			check({inhibit_active, output_enable}, 2'b10);
			apb(1, OUTPUT_OFFSET, 1);
			err_is(ERR_CONFLICT);
			set_pin(!inh, 4);
			check(output_enable, 1);
			apb(1, OUTPUT_OFFSET, 0);
			settle();
			check(output_enable, 0);
			apb(0, OUTPUT_OFFSET, 0);
			check(rd & 32'h7, 0);
			apb(1, OUTPUT_OFFSET, 1);
			settle();
			apb(0, OUTPUT_OFFSET, 0);
			check(rd & 32'h7, 32'h5);
		end
		$display("inhibit test done");
	endtask

	task t_enables;
		logic e;
		for (int p = 1; p <= 2; p++) begin
			for (int lv = 0; lv <= 1; lv++) begin
				e = (p == 1) ? lv : !lv;
				cfg(p, 0);
				set_pin(lv, 4);
				check(output_enable, e);
				key();
				check(output_enable, e);
				apb(1, OUTPUT_OFFSET, !e);
				settle();
				check(output_enable, e);
				err_is(ERR_CONFLICT);
			end
		end
		$display("enables test done");
	endtask

	task t_disabled;
		cfg(0, 0);
		set_pin(0, 4);
		check(output_enable, 1);
		set_pin(1, 4);
		check(output_enable, 1);
		key();
		check(output_enable, 0);
		key();
		check(output_enable, 1);
		apb(1, CONFIG_OFFSET, 32'h100);
		settle();
		check(output_enable, 1);
		apb(0, CONFIG_OFFSET, 0);
		check(rd & 32'h137, 32'h100);
		$display("disabled test done");
	endtask

	task t_latch;
		cfg(5, 0);
		set_pin(0, 4);
		set_pin(1, 4);
		check(output_enable, 1);
		set_pin(0, 16);
		check(output_enable, 0);
		set_pin(1, 8);
		check(output_enable, 0);
		apb(1, OUTPUT_OFFSET, 1);
		settle();
		check(output_enable, 1);
		$display("latch test done");
	endtask

	task t_load;
		for (int l = 0; l <= 2; l++) begin
			cfg(3, l);
			settle();
			check(load_select, l);
			apb(0, CONFIG_OFFSET, 0);
			check(rd[5:4], l);
			apb(1, PERSIST_OFFSET, 32'h10);
			#1;
			check(nv_save, 32'h10);
			settle();
			check(nv_load, l);
		end
		cfg(4, 2);
		cfg(7, 3);
		apb(0, CONFIG_OFFSET, 0);
		check(rd & 32'h37, 32'h24);
		for (int g = 0; g <= 3; g++) begin
			apb(1, PERSIST_OFFSET, 1 << g);
			#1;
			check(nv_save, 1 << g);
		end
		settle();
		check(nv_policy, 4);
		apb(0, PERSIST_OFFSET, 0);
		check(rd & 32'h37, 32'h24);
		$display("load and persist test done");
	endtask

	task t_list;
		cfg(0, 0);
		apb(1, LIST_OFFSET, 32'h203);
		err_is(ERR_COMMAND);
		apb(1, LIST_OFFSET, 32'h103);
		apb(1, OUTPUT_OFFSET, 0);
		err_is(ERR_CONFLICT);
		#1;
		check(output_enable, 1);
		@(posedge clock);
		list_done <= 1;
		@(posedge clock);
		list_done <= 0;
		apb(1, OUTPUT_OFFSET, 0);
		err_is(ERR_NONE);
		settle();
		check(output_enable, 0);
		$display("list test done");
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge clock);
		resetn <= 1;
		t_reset();
		t_inhibit();
		t_enables();
		t_disabled();
		t_latch();
		t_load();
		t_list();
		print_verdict();
	end
endmodule
